/* pp_fifo.sv */
// Shared byte FIFO with a registered read word.
// Assumes one clock; depth must be a power of two.
module pp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic mclk,       // System clock
  input wire logic rst_n,      // Synchronous reset, active low
  pp_fifo_if.fifo  f           // Push and pop channels
);
  localparam int AW = $clog2(D);

  if (D < 2 || (D & (D - 1)) != 0 || W != $bits(f.in_data)) begin : g_chk
    $error("pp_fifo: depth must be a power of two and width must match");
  end

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0]   cnt_r;
  logic [W-1:0]  out_data_r;
  wire           push = f.in_valid & f.in_ready;
  wire           pop  = f.out_valid & f.out_ready;

  assign f.in_ready  = cnt_r != (AW + 1)'(D);
  assign f.out_valid = cnt_r != '0;
  assign f.out_data  = out_data_r;
  assign rp_nxt      = pop ? rp_r + 1'b1 : rp_r;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_r] <= f.in_data;
    end
    // Bypass keeps the head word valid when writing into a draining slot
    out_data_r <= (push && wp_r == rp_nxt) ? f.in_data : mem[rp_nxt];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= push ? wp_r + 1'b1 : wp_r;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  full_no_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_r == (AW + 1)'(D) && !pop |=> cnt_r == (AW + 1)'(D))
    else $error("fifo overfilled");
  push_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    push && !pop |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("fifo count did not rise on push");
endmodule // pp_fifo

/* pp_fifo_if.sv */
// Push and pop channels between the port engine and its byte FIFO.
// Assumes both ends run on the same clock.
interface pp_fifo_if #(
  parameter int W = 8
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport src  (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface : pp_fifo_if

/* pp_periph.sv */
// Behavioural peripheral on the far side of the parallel bus.
// Assumes strobes are sampled on mclk; the bench merges pd with the port's drive.
module pp_periph (
  input  wire logic       mclk,    // Bench clock
  input  wire logic       rst_n,   // Synchronous reset, active low
  input  wire logic       ds_n,    // Data strobe from port
  input  wire logic       as_n,    // Address strobe from port
  input  wire logic [7:0] byte_i,  // Byte to answer with
  input  wire logic [7:0] delay_i, // Cycles before answering
  input  wire logic       stuck_i, // Never release hold
  output logic            hold_n,  // Wait line, low holds
  output logic      [7:0] bus_o,   // Parallel bus as seen
  output logic            drive_o  // High while driving
);
  logic [7:0] cnt_r;
  logic [7:0] last_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_n  <= 1'b0;
      drive_o <= 1'b0;
      cnt_r   <= 8'h00;
      last_r  <= 8'h00;
    end else if (!ds_n || !as_n) begin
      if (cnt_r < delay_i) begin
        cnt_r <= cnt_r + 8'h01;
      end else begin
        drive_o <= 1'b1;
        last_r  <= byte_i;
        hold_n  <= !stuck_i && drive_o;
      end
    end else begin
      drive_o <= 1'b0;
      hold_n  <= 1'b0;
      cnt_r   <= 8'h00;
    end
  end
  // A floated bus shows the inverse so a stale byte cannot pass
  assign bus_o = drive_o ? last_r : ~last_r;
endmodule // pp_periph

/* pp_pkg.sv */
// Constants shared by the parallel port read engine and its byte FIFO.
// Assumes a single 40 MHz clock domain; register indices are host_addr codes.
// Function
// - Hold iochrdy low while peripheral_hold_n is low during a read.
// - Direction bit set: write_indicate_n released and parallel bus floated.
// - Host read of a port register asserts data or address strobe; code strobes only for EPP address and data reads in EPP mode.
// - Keep iochrdy low until hold released or the cycle timer expires.
// - Strobe is removed when the host removes its read command.
// - write_indicate_n is active low and marks a write.
// - data_strobe_n is active low and marks a data access.
// - addr_strobe_n is active low and marks an address access.
// - Peripheral interrupt is active high, passed through uninverted.
// - Active low port_reset_n returns the peripheral to its initial mode.
// - bus_direction_out high only when direction bit set or reading.
// - Only write_indicate_n may be overridden by the control strobe bit.
// - Port word is eight bits wide.
// - config_b: compression flag on top, irq level, irq and dma selects.
// - All FIFO registers share one 16 byte buffer.
// - Status and control registers are reachable in every mode.
// - Abort a cycle after 10 us and flag it in status bit 0.
package pp_pkg;
  localparam int       PW         = 8;
  localparam int       FIFO_DEPTH = 16;
  localparam int       AW         = 4;
  // Register indices on host_addr
  localparam logic [3:0] A_DATA   = 4'h0;
  localparam logic [3:0] A_STAT   = 4'h1;
  localparam logic [3:0] A_CTRL   = 4'h2;
  localparam logic [3:0] A_EADDR  = 4'h3;
  localparam logic [3:0] A_EDATA  = 4'h4;
  localparam logic [3:0] A_FIFO   = 4'h8;
  localparam logic [3:0] A_CFGA   = 4'h9;
  localparam logic [3:0] A_CFGB   = 4'ha;
  localparam logic [3:0] A_ECR    = 4'hb;
  // port_control, status and ECR bit positions and the EPP mode code
  localparam int       C_STB      = 0;
  localparam int       C_AFD      = 1;
  localparam int       C_INIT     = 2;
  localparam int       C_SELIN    = 3;
  localparam int       C_ACKEN    = 4;
  localparam int       C_DIR      = 5;
  localparam int       S_TOUT     = 0;
  localparam int       E_MODE_LSB = 5;
  localparam logic [2:0] MODE_EPP = 3'h4;
  // Values after reset, control write mask and fixed read values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_MSK = 8'h3f;
  localparam logic [5:0] CFGB_RST = 6'h00;
  localparam logic [5:0] ECR_RST  = 6'h20;
  localparam logic [7:0] CFGA_VAL = 8'h10;
  localparam logic       COMPRESS = 1'b0;
  // Cycle watchdog
  localparam int       CLK_NS     = 25;
  localparam int       TOUT_NS    = 10000;
  localparam int       TOUT_CYC   = (TOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int       TW         = 9;
  typedef enum logic [3:0] {
    RD_IDLE = 4'b0001,
    RD_STRB = 4'b0010,
    RD_HOLD = 4'b0100,
    RD_TOUT = 4'b1000
  } pp_rd_e;
endpackage : pp_pkg

/* pp_port.sv */
// Parallel port register set and peripheral read cycle engine.
// Assumes ISA-style strobes and parallel pins are asynchronous to mclk.
module pp_port #(
  parameter int PW         = pp_pkg::PW,
  parameter int FIFO_DEPTH = pp_pkg::FIFO_DEPTH
) (
  input  wire logic          mclk,              // 40 MHz clock
  input  wire logic          rst_n,             // Synchronous reset, low
  input  wire logic [3:0]    host_addr,         // Register index
  input  wire logic          host_ior_n,        // Host read command, low
  input  wire logic          host_iow_n,        // Host write command, low
  input  wire logic [PW-1:0] host_byte_bus_in,  // Host data in
  output logic      [PW-1:0] host_byte_bus_out, // Host data out
  output logic               host_byte_bus_oe,  // Host data drive enable
  output logic               iochrdy,           // Host ready, low holds off
  output logic               host_irq,          // Interrupt toward host
  input  wire logic [PW-1:0] pd_in,             // Parallel bus in
  output logic      [PW-1:0] pd_out,            // Parallel bus out
  output logic               pd_oe,             // Parallel bus drive enable
  output logic               write_indicate_n,  // Write marker, low
  output logic               data_strobe_n,     // Data strobe, low
  output logic               addr_strobe_n,     // Address strobe, low
  output logic               bus_direction_out, // High reads, low writes
  output logic               port_reset_n,      // Peripheral reset, low
  input  wire logic          peripheral_hold_n, // Peripheral wait, low
  input  wire logic          peripheral_irq_in, // Peripheral interrupt
  input  wire logic          paper_end_in,      // Paper end status
  input  wire logic          select_in,         // Selected status
  input  wire logic          fault_n_in         // Fault status, low
);
  localparam int SW = 4 + 2 + PW + PW + 5;
  localparam logic [pp_pkg::TW-1:0] TLAST = pp_pkg::TW'(pp_pkg::TOUT_CYC - 1);

  if (PW != 8 || FIFO_DEPTH != 16) begin : g_chk
    $error("pp_port: port word must be 8 bits and FIFO 16 deep");
  end

  // Two-stage synchroniser for every asynchronous input
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic          ior_q_r;
  logic          iow_q_r;
  wire  [SW-1:0] pins = {host_addr, host_ior_n, host_iow_n, host_byte_bus_in,
                         pd_in, peripheral_hold_n, peripheral_irq_in,
                         paper_end_in, select_in, fault_n_in};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end

  wire [3:0]    addr_s  = s2_r[SW-1 -: 4];
  wire          ior_s   = s2_r[SW-5];
  wire          iow_s   = s2_r[SW-6];
  wire [PW-1:0] wdat_s  = s2_r[SW-7 -: PW];
  wire [PW-1:0] pd_s    = s2_r[4+PW -: PW];
  wire          hold_s  = s2_r[4];
  wire          irq_s   = s2_r[3];
  wire          pe_s    = s2_r[2];
  wire          slct_s  = s2_r[1];
  wire          fault_s = s2_r[0];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ior_q_r <= 1'b1;
      iow_q_r <= 1'b1;
    end else begin
      ior_q_r <= ior_s;
      iow_q_r <= iow_s;
    end
  end

  wire ior_fall = ior_q_r & ~ior_s;
  wire ior_rise = ~ior_q_r & ior_s;
  wire iow_fall = iow_q_r & ~iow_s;

  // Address decode; status and control answer in every mode
  wire sel_d   = addr_s == pp_pkg::A_DATA;
  wire sel_st  = addr_s == pp_pkg::A_STAT;
  wire sel_c   = addr_s == pp_pkg::A_CTRL;
  wire sel_ea  = addr_s == pp_pkg::A_EADDR;
  wire sel_ed  = addr_s == pp_pkg::A_EDATA;
  wire sel_f   = addr_s == pp_pkg::A_FIFO;
  wire sel_ca  = addr_s == pp_pkg::A_CFGA;
  wire sel_cb  = addr_s == pp_pkg::A_CFGB;
  wire sel_ecr = addr_s == pp_pkg::A_ECR;
  wire hit     = sel_d | sel_st | sel_c | sel_ea | sel_ed | sel_f | sel_ca | sel_cb | sel_ecr;

  // Software registers
  logic [7:0] data_r;
  logic [7:0] ctl_r;
  logic [5:0] cfgb_r;
  logic [5:0] ecr_r;
  logic       tout_r;
  wire        wr       = iow_fall;
  wire        ctl_dir  = ctl_r[pp_pkg::C_DIR];
  wire        epp_mode = ecr_r[5:3] == pp_pkg::MODE_EPP;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_r <= pp_pkg::DATA_RST;
      ctl_r  <= pp_pkg::CTRL_RST;
      cfgb_r <= pp_pkg::CFGB_RST;
      ecr_r  <= pp_pkg::ECR_RST;
    end else begin
      if (wr && sel_d) begin
        data_r <= wdat_s;
      end
      if (wr && sel_c) begin
        ctl_r <= wdat_s & pp_pkg::CTRL_MSK;
      end
      if (wr && sel_cb) begin
        cfgb_r <= wdat_s[5:0];
      end
      if (wr && sel_ecr) begin
        ecr_r <= wdat_s[7:2];
      end
    end
  end

  // One FIFO serves every FIFO register; a push while full is dropped
  pp_fifo_if #(.W(PW)) fif ();

  pp_fifo #(
    .W (PW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .f     (fif)
  );

  assign fif.in_valid  = wr & sel_f;
  assign fif.in_data   = wdat_s;
  assign fif.out_ready = ior_rise & sel_f;

  // Read cycle engine
  pp_pkg::pp_rd_e       st_r;
  pp_pkg::pp_rd_e       st_nxt;
  logic [pp_pkg::TW-1:0] tmr_r;
  logic                 isaddr_r;
  logic [PW-1:0]        rd_byte_r;
  wire                  rd_start = ior_fall & (sel_ea | sel_ed) & epp_mode;
  wire                  tmo      = tmr_r == TLAST;
  wire                  isaddr_nxt = rd_start ? sel_ea : isaddr_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      pp_pkg::RD_IDLE: begin
        if (rd_start) begin
          st_nxt = pp_pkg::RD_STRB;
        end
      end
      pp_pkg::RD_STRB: begin
        if (ior_s) begin
          st_nxt = pp_pkg::RD_IDLE;
        end else if (tmo) begin
          st_nxt = pp_pkg::RD_TOUT;
        end else if (hold_s) begin
          st_nxt = pp_pkg::RD_HOLD;
        end
      end
      pp_pkg::RD_HOLD: begin
        if (ior_s) begin
          st_nxt = pp_pkg::RD_IDLE;
        end else if (tmo) begin
          st_nxt = pp_pkg::RD_TOUT;
        end
      end
      pp_pkg::RD_TOUT: begin
        if (ior_s) begin
          st_nxt = pp_pkg::RD_IDLE;
        end
      end
      default: st_nxt = pp_pkg::RD_IDLE;
    endcase
  end

  wire strobing  = st_nxt == pp_pkg::RD_STRB || st_nxt == pp_pkg::RD_HOLD;
  wire reading   = st_nxt != pp_pkg::RD_IDLE;
  wire tout_set  = st_nxt == pp_pkg::RD_TOUT && st_r != pp_pkg::RD_TOUT;
  wire tout_clr  = ior_rise & sel_st;
  // Watchdog spans the whole command, not only the wait phase
  wire counting  = st_r == pp_pkg::RD_STRB || st_r == pp_pkg::RD_HOLD;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r      <= pp_pkg::RD_IDLE;
      tmr_r     <= '0;
      isaddr_r  <= 1'b0;
      rd_byte_r <= '0;
      tout_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      tmr_r     <= (counting && !tmo) ? tmr_r + 1'b1 : '0;
      isaddr_r  <= isaddr_nxt;
      if (st_r == pp_pkg::RD_STRB && hold_s) begin
        rd_byte_r <= pd_s;
      end
      // Set wins over a status read that clears in the same cycle
      tout_r    <= tout_set | (tout_r & ~tout_clr);
    end
  end

  // Host read data
  wire [7:0] stat_w = {~hold_s, irq_s, pe_s, slct_s, fault_s, 2'b00, tout_r};
  wire [7:0] cfgb_w = {pp_pkg::COMPRESS, irq_s, cfgb_r};
  wire [7:0] ecr_w  = {ecr_r, ~fif.in_ready, ~fif.out_valid};
  wire [7:0] epp_w  = (st_r == pp_pkg::RD_HOLD) ? rd_byte_r : pd_s;
  wire [7:0] dat_w  = ctl_dir ? pd_s : data_r;
  wire [7:0] rd_mux = sel_d   ? dat_w :
                      sel_st  ? stat_w :
                      sel_c   ? ctl_r :
                      (sel_ea | sel_ed) ? epp_w :
                      sel_f   ? fif.out_data :
                      sel_ca  ? pp_pkg::CFGA_VAL :
                      sel_cb  ? cfgb_w :
                      sel_ecr ? ecr_w : 8'h00;

  // Pin drivers; idle strobe levels follow the control register
  wire dstb_nxt = strobing ? isaddr_nxt : ~ctl_r[pp_pkg::C_AFD];
  wire astb_nxt = strobing ? ~isaddr_nxt : ~ctl_r[pp_pkg::C_SELIN];
  // Control strobe bit is the one override allowed during a cycle
  wire wrn_nxt  = ~(ctl_r[pp_pkg::C_STB] | (~ctl_dir & ~reading));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_byte_bus_out <= '0;
      host_byte_bus_oe  <= 1'b0;
      iochrdy           <= 1'b1;
      host_irq          <= 1'b0;
      pd_out            <= '0;
      pd_oe             <= 1'b0;
      write_indicate_n  <= 1'b1;
      data_strobe_n     <= 1'b1;
      addr_strobe_n     <= 1'b1;
      bus_direction_out <= 1'b0;
      port_reset_n      <= 1'b0;
    end else begin
      host_byte_bus_out <= rd_mux;
      host_byte_bus_oe  <= ~ior_s & hit;
      iochrdy           <= ~(st_nxt == pp_pkg::RD_STRB && !hold_s);
      host_irq          <= irq_s & ctl_r[pp_pkg::C_ACKEN];
      pd_out            <= data_r;
      pd_oe             <= ~ctl_dir & ~reading;
      write_indicate_n  <= wrn_nxt;
      data_strobe_n     <= dstb_nxt;
      addr_strobe_n     <= astb_nxt;
      bus_direction_out <= ctl_dir | reading;
      port_reset_n      <= ctl_r[pp_pkg::C_INIT];
    end
  end

  hold_rdy_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == pp_pkg::RD_STRB && !hold_s && !ior_s && !tmo |=> !iochrdy)
    else $error("iochrdy released while peripheral holds");

  dir_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_dir && $past(ctl_dir) |-> !pd_oe && write_indicate_n == ~$past(ctl_r[0]))
    else $error("bus driven or write shown with direction set");

  strobe_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == pp_pkg::RD_IDLE && rd_start |=> data_strobe_n != addr_strobe_n)
    else $error("no single strobe at read start");

  tout_abort_a: assert property (@(posedge mclk) disable iff (!rst_n)
    counting && tmo && !ior_s |=> st_r == pp_pkg::RD_TOUT && tout_r && iochrdy
      ##0 data_strobe_n && addr_strobe_n)
    else $error("watchdog did not abort the cycle");

  tmr_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tmr_r <= TLAST)
    else $error("watchdog count ran past its limit");

  strobe_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r != pp_pkg::RD_IDLE && ior_s |=> data_strobe_n && addr_strobe_n
      ##1 st_r == pp_pkg::RD_IDLE)
    else $error("strobe kept after read command removed");

  dir_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r != pp_pkg::RD_IDLE |-> bus_direction_out)
    else $error("direction low during read cycle");

  irq_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(irq_s) && ctl_r[pp_pkg::C_ACKEN] |=> host_irq)
    else $error("interrupt not passed through");

  cfga_const_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sel_ca |=> host_byte_bus_out == 8'h10)
    else $error("config_a value wrong");

  read_byte_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == pp_pkg::RD_STRB && hold_s && !ior_s && !tmo && (sel_ed | sel_ea)
      |=> ##1 host_byte_bus_out == $past(pd_s, 2))
    else $error("host did not get the latched byte");
endmodule // pp_port

/* tb_parallel_port_epp_read_ecp_regs.sv */
// Self-checking bench for the parallel port register set and read engine.
// Assumes pp_port at default widths and the pp_periph model on the parallel side.
module tb_parallel_port_epp_read_ecp_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rst_n, ior_n, iow_n, irq_in, stuck;
  logic       oe, rdy, hirq, pd_oe, wr_n, ds_n, as_n, dir, prst_n, hold_n, drv;
  logic [3:0] addr;
  logic [7:0] din, dout, pd_out, pd_in, per_bus, per_byte, dly, v;
  int         miscompares, comparisons, n;
  assign pd_in = pd_oe ? pd_out : per_bus;
  pp_port u_pp_port (.mclk(mclk), .rst_n(rst_n), .host_addr(addr), .host_ior_n(ior_n),
    .host_iow_n(iow_n), .host_byte_bus_in(din), .host_byte_bus_out(dout), .host_byte_bus_oe(oe),
    .iochrdy(rdy), .host_irq(hirq), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
    .write_indicate_n(wr_n), .data_strobe_n(ds_n), .addr_strobe_n(as_n), .bus_direction_out(dir),
    .port_reset_n(prst_n), .peripheral_hold_n(hold_n), .peripheral_irq_in(irq_in),
    .paper_end_in(1'b1), .select_in(1'b0), .fault_n_in(1'b1));
  pp_periph u_pp_periph (.mclk(mclk), .rst_n(rst_n), .ds_n(ds_n), .as_n(as_n), .byte_i(per_byte),
    .delay_i(dly), .stuck_i(stuck), .hold_n(hold_n), .bus_o(per_bus), .drive_o(drv));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    addr = a;
    din  = d;
    cyc(1);
    iow_n = 1'b0;
    cyc(6);
    iow_n = 1'b1;
    cyc(4);
  endtask
  task ior_on(input logic [3:0] a);
    addr = a;
    cyc(1);
    ior_n = 1'b0;
  endtask
  task ior_off;
    ior_n = 1'b1;
    cyc(5);
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    ior_on(a);
    cyc(6);
    d = dout;
    ior_off();
  endtask
  // Bounded wait so a stuck handshake still ends the run
  task wait_rdy(input int lim);
    n = 0;
    while (rdy !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task t_reset;
    chk("iochrdy", rdy, 1);
    chk("port_reset_n", prst_n, 0);
    chk("strobes", {ds_n, as_n}, 3);
    chk("direction", dir, 0);
    chk("write_ind", wr_n, 0);
    rd(pp_pkg::A_ECR, v);
    chk("ecr", v, {pp_pkg::ECR_RST, 2'b01});
  endtask
  task t_regs;
    rd(pp_pkg::A_CFGA, v);
    chk("config_a", v, 8'h10);
    wr(pp_pkg::A_CFGA, 8'hff);
    rd(pp_pkg::A_CFGA, v);
    chk("config_a", v, 8'h10);
    wr(pp_pkg::A_CFGB, 8'hff);
    rd(pp_pkg::A_CFGB, v);
    chk("compress", v[7], pp_pkg::COMPRESS);
    chk("config_b", v & 8'hbf, 8'h3f);
    wr(pp_pkg::A_CTRL, 8'hc4);
    rd(pp_pkg::A_CTRL, v);
    chk("control", v, 8'h04);
    chk("port_reset_n", prst_n, 1);
    rd(pp_pkg::A_STAT, v);
    chk("status", v, 8'ha8);
    ior_on(4'h5);
    cyc(6);
    chk("unmapped_oe", oe, 0);
    ior_off();
    ior_on(pp_pkg::A_CFGA);
    cyc(6);
    chk("mapped_oe", oe, 1);
    ior_off();
    wr(pp_pkg::A_ECR, 8'h00);
    ior_on(pp_pkg::A_EDATA);
    cyc(6);
    chk("no_mode_strobe", {ds_n, as_n}, 3);
    chk("no_mode_rdy", rdy, 1);
    ior_off();
    wr(pp_pkg::A_ECR, 8'h80);
  endtask
  task t_dir;
    wr(pp_pkg::A_CTRL, 8'h24);
    chk("write_ind", wr_n, 1);
    chk("pd_oe", pd_oe, 0);
    chk("direction", dir, 1);
    wr(pp_pkg::A_CTRL, 8'h04);
    chk("direction", dir, 0);
    chk("write_ind", wr_n, 0);
    chk("pd_oe", pd_oe, 1);
    wr(pp_pkg::A_DATA, 8'ha5);
    chk("pd_out", pd_out, 8'ha5);
    rd(pp_pkg::A_DATA, v);
    chk("data_reg", v, 8'ha5);
  endtask
  task t_data_read;
    per_byte = 8'h5a;
    dly = 8'd20;
    ior_on(pp_pkg::A_EDATA);
    cyc(6);
    chk("data_strobe", {ds_n, as_n}, 1);
    chk("iochrdy", rdy, 0);
    chk("direction", dir, 1);
    chk("pd_oe", pd_oe, 0);
    chk("write_ind", wr_n, 1);
    wait_rdy(100);
    chk("hold_wait", 8'(n > 10 && n < 100), 1);
    cyc(3);
    chk("read_byte", dout, 8'h5a);
    chk("strobe_held", ds_n, 0);
    ior_off();
    chk("strobe_end", ds_n, 1);
    chk("direction", dir, 0);
  endtask
  task t_addr_read;
    wr(pp_pkg::A_CTRL, 8'h05);
    per_byte = 8'hc3;
    dly = 8'd0;
    ior_on(pp_pkg::A_EADDR);
    cyc(5);
    chk("addr_strobe", {ds_n, as_n}, 2);
    chk("write_ind", wr_n, 0);
    chk("pd_oe", pd_oe, 0);
    wait_rdy(100);
    cyc(3);
    chk("read_addr", dout, 8'hc3);
    ior_off();
    chk("addr_end", as_n, 1);
    wr(pp_pkg::A_CTRL, 8'h04);
  endtask
  task t_timeout;
    stuck = 1'b1;
    ior_on(pp_pkg::A_EDATA);
    cyc(6);
    chk("iochrdy", rdy, 0);
    wait_rdy(600);
    chk("iochrdy", rdy, 1);
    chk("tout_cycles", 8'(n >= 395 && n <= 410), 1);
    chk("strobes", {ds_n, as_n}, 3);
    ior_off();
    stuck = 1'b0;
    rd(pp_pkg::A_STAT, v);
    chk("tout_flag", v[0], 1);
    rd(pp_pkg::A_STAT, v);
    chk("tout_clear", v[0], 0);
  endtask
  task t_irq;
    wr(pp_pkg::A_CTRL, 8'h14);
    irq_in = 1'b1;
    cyc(4);
    chk("host_irq", hirq, 1);
    rd(pp_pkg::A_STAT, v);
    chk("irq_status", v[6], 1);
    irq_in = 1'b0;
    cyc(4);
    chk("host_irq", hirq, 0);
    wr(pp_pkg::A_CTRL, 8'h04);
  endtask
  task t_fifo;
    for (int i = 0; i < 16; i++) wr(pp_pkg::A_FIFO, 8'h30 + 8'(i));
    rd(pp_pkg::A_ECR, v);
    chk("fifo_full", v & 8'h03, 2);
    wr(pp_pkg::A_FIFO, 8'hee);
    for (int i = 0; i < 16; i++) begin
      rd(pp_pkg::A_FIFO, v);
      chk("fifo_word", v, 8'h30 + 8'(i));
    end
    rd(pp_pkg::A_ECR, v);
    chk("fifo_empty", v & 8'h03, 1);
  endtask
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
  initial begin
    rst_n    = 1'b0;
    ior_n    = 1'b1;
    iow_n    = 1'b1;
    addr     = 4'h0;
    din      = 8'h00;
    irq_in   = 1'b0;
    stuck    = 1'b0;
    per_byte = 8'h00;
    dly      = 8'h00;
    cyc(4);
    rst_n = 1'b1;
    cyc(4);
    t_reset();
    t_regs();
    t_dir();
    t_data_read();
    t_addr_read();
    t_timeout();
    t_irq();
    t_fifo();
    stop_test();
  end
endmodule // tb_parallel_port_epp_read_ecp_regs
